/* src/lmd_defines.svh */
// Offsets, field positions, reset values and timing counts of the LCD drive timing block
`ifndef LMD_DEFINES_SVH
`define LMD_DEFINES_SVH
// Register byte offsets
`define LMD_OFF_CTRL     8'h00
`define LMD_OFF_RAM      8'h04
`define LMD_OFF_STATUS   8'h08
// Control field positions
`define LMD_CTRL_EN      0
`define LMD_CTRL_MODE_LO 1
`define LMD_CTRL_MODE_HI 2
`define LMD_CTRL_HALF    3
// RAM access field positions
`define LMD_RAM_COL_HI   6
`define LMD_RAM_DAT_LO   8
`define LMD_RAM_DAT_HI   11
// Reset values: 1:4 multiplex, third bias, display off
`define LMD_RST_MODE     2'h3
`define LMD_RST_HALF     1'b0
`define LMD_RST_EN       1'b0
// Timing
`define LMD_REF_HZ       25000000
`define LMD_CLK_SLOW_HZ  1970
`define LMD_CLK_FAST_HZ  2640
`define LMD_OSC_DIV      64
`define LMD_FRAME_TICKS  24
// AXI responses
`define LMD_RESP_OKAY    2'h0
`define LMD_RESP_SLVERR  2'h2
`endif

/* src/lmd_pkg.sv */
// Types shared by the LCD drive timing block
package lmd_pkg;
	// Drive mode, value = active backplanes minus one
	typedef enum logic [1:0] {
		LMD_STATIC = 2'h0,
		LMD_MUX2   = 2'h1,
		LMD_MUX3   = 2'h2,
		LMD_MUX4   = 2'h3
	} lmd_mode_t;
	// Drive level: 0 = ground, 3 = lcd_drive_supply, 1/2 = thirds
	typedef logic [1:0] lmd_level_t;
endpackage

/* src/lmd_drive_timing.sv */
// LCD multiplex drive timing, display RAM and AXI4-Lite register slave
`include "lmd_defines.svh"

module lmd_drive_timing #(
	parameter int NSEG = 80
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire logic                     osc_select_pin,
	input  wire logic                     frame_rate_select_pin,
	input  wire logic                     clk_pin_i,
	output logic                          clk_pin_o,
	output logic                          clk_pin_oe_n,
	input  wire logic                     sync_i,
	output logic                          sync_o,
	output logic                          sync_oe_n,
	output lmd_pkg::lmd_level_t [3:0]     backplane_outputs,
	output lmd_pkg::lmd_level_t [NSEG-1:0] segment_outputs,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);
	// Oscillator periods in reference cycles
	localparam int SLOW_I = `LMD_REF_HZ / (`LMD_CLK_SLOW_HZ * `LMD_OSC_DIV);
	localparam int FAST_I = `LMD_REF_HZ / (`LMD_CLK_FAST_HZ * `LMD_OSC_DIV);
	localparam logic [7:0] OSC_SLOW = 8'(SLOW_I - 1);
	localparam logic [7:0] OSC_FAST = 8'(FAST_I - 1);
	localparam logic [4:0] FRAME_LAST = 5'(`LMD_FRAME_TICKS - 1);

	////////////////////////////////////////////////////////////////////
	// Helper functions
	////////////////////////////////////////////////////////////////////
	// Phase length: frame split into 2n equal halves-of-phase
	function automatic logic [4:0] slot_len(lmd_pkg::lmd_mode_t m);
		case (m)
			lmd_pkg::LMD_STATIC: slot_len = 5'd12;
			lmd_pkg::LMD_MUX2:   slot_len = 5'd6;
			lmd_pkg::LMD_MUX3:   slot_len = 5'd4;
			default:             slot_len = 5'd3;
		endcase
	endfunction
	// Backplane index to RAM row it carries
	function automatic logic [1:0] bp_row(int b, lmd_pkg::lmd_mode_t m);
		case (m)
			lmd_pkg::LMD_STATIC: bp_row = 2'h0;
			lmd_pkg::LMD_MUX2:   bp_row = 2'(b % 2);
			lmd_pkg::LMD_MUX3:   bp_row = (b == 3) ? 2'h1 : 2'(b);
			default:             bp_row = 2'(b);
		endcase
	endfunction
	// Level for one pin; inversion flips about the middle
	function automatic lmd_pkg::lmd_level_t drv(logic is_bp, logic act,
			logic pol, logic stat, logic half);
		lmd_pkg::lmd_level_t l;
		if (is_bp)
			l = act ? 2'h3 : 2'h1;
		else
			l = act ? 2'h0 : (stat ? 2'h3 : (half ? 2'h1 : 2'h2));
		// Half-bias midpoint stays put under inversion
		if (pol && !(half && !stat && l == 2'h1))
			l = 2'h3 - l;
		drv = l;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Control state
	////////////////////////////////////////////////////////////////////
	lmd_pkg::lmd_mode_t mode_q;          // Drive mode
	logic               half_q;          // Half bias select
	logic               en_q;            // Display enable
	logic [3:0]         ram_q [NSEG];    // Display RAM
	logic [11:0]        ram_acc_q;       // Last RAM access word
	logic [7:0]         osc_cnt_q;       // Oscillator period count
	logic [5:0]         presc_q;         // Divide-by-64 prescaler
	logic               ext_q;           // Previous clock pin sample
	logic [4:0]         frame_q;         // Working clock in frame
	logic [1:0]         row_q;           // Current RAM row
	logic               pol_q;           // Second half of frame
	logic [NSEG-1:0]    disp_q;          // Display register

	////////////////////////////////////////////////////////////////////
	// Working clock
	////////////////////////////////////////////////////////////////////
	wire [7:0] osc_per  = frame_rate_select_pin ? OSC_SLOW : OSC_FAST;
	wire       osc_tick = !osc_select_pin && (osc_cnt_q == osc_per);
	wire       int_tick = osc_tick && (presc_q == 6'h3f);
	wire       ext_tick = osc_select_pin && clk_pin_i && !ext_q;
	wire       fclk_tick = int_tick || ext_tick;

	// Oscillator and prescaler run only when selected
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			osc_cnt_q <= 8'h00;
			presc_q   <= 6'h00;
			ext_q     <= clk_pin_i;  // Track the pin so release gives no false edge
		end else begin
			osc_cnt_q <= (osc_tick || osc_select_pin) ? 8'h00 : osc_cnt_q + 8'h01;
			presc_q   <= osc_tick ? presc_q + 6'h01 : presc_q;
			ext_q     <= clk_pin_i;
		end
	end

	// Clock pin out for cascade; released when external source chosen
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clk_pin_o    <= 1'b0;
			clk_pin_oe_n <= 1'b1;
		end else begin
			clk_pin_o    <= presc_q[5];
			clk_pin_oe_n <= osc_select_pin;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frame sequencing
	////////////////////////////////////////////////////////////////////
	// Another device pulled sync while we are mid-frame
	wire       resync   = !sync_i && (frame_q != 5'h00);
	wire [4:0] frame_d  = (resync || frame_q == FRAME_LAST) ? 5'h00
	                    : frame_q + 5'h01;
	wire [4:0] len      = slot_len(mode_q);
	wire [4:0] slot_d   = frame_d / len;
	wire [2:0] nrow     = 3'(mode_q) + 3'h1;
	wire       phase_st = (frame_d % len) == 5'h00;
	wire [1:0] row_d    = 2'(slot_d % 5'(nrow));
	wire       pol_d    = slot_d >= 5'(nrow);
	logic [NSEG-1:0] disp_d;

	// Pick one RAM row across all columns
	always_comb begin
		for (int c = 0; c < NSEG; c++)
			disp_d[c] = ram_q[c][row_d];
	end

	// Advance on each working clock; reload at phase start
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_q <= 5'h00;
			row_q   <= 2'h0;
			pol_q   <= 1'b0;
			disp_q  <= '0;
		end else if (fclk_tick) begin
			frame_q <= frame_d;
			if (phase_st) begin
				row_q  <= row_d;
				pol_q  <= pol_d;
				disp_q <= disp_d;
			end
		end
	end

	// Open-drain sync: pull low for the first clock of each frame
	assign sync_o    = 1'b0;
	assign sync_oe_n = (frame_q != 5'h00);

	////////////////////////////////////////////////////////////////////
	// Output levels
	////////////////////////////////////////////////////////////////////
	wire stat = (mode_q == lmd_pkg::LMD_STATIC);
	// Registered pin levels; disabled display parks at supply
	always_ff @(posedge ref_clk) begin
		for (int b = 0; b < 4; b++) begin
			if (!rst_n || !en_q)
				backplane_outputs[b] <= 2'h3;
			else
				backplane_outputs[b] <= drv(1'b1, bp_row(b, mode_q) == row_q,
					pol_q, stat, half_q);
		end
		for (int c = 0; c < NSEG; c++) begin
			if (!rst_n || !en_q)
				segment_outputs[c] <= 2'h3;
			else
				segment_outputs[c] <= drv(1'b0, disp_q[c], pol_q, stat,
					half_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	////////////////////////////////////////////////////////////////////
	logic       aw_have_q;  // Write address held
	logic       w_have_q;   // Write data held
	logic [7:0] aw_q;       // Held write address
	logic [31:0] wd_q;      // Held write data
	logic [3:0] ws_q;       // Held strobes
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;
	wire wr_map = aw_q == `LMD_OFF_CTRL || aw_q == `LMD_OFF_RAM
	           || aw_q == `LMD_OFF_STATUS;
	wire [6:0] wcol = wd_q[`LMD_RAM_COL_HI:0];
	wire [6:0] rcol = ram_acc_q[`LMD_RAM_COL_HI:0];
	wire [3:0] rram = (rcol < 7'(NSEG)) ? ram_q[rcol] : 4'h0;

	// Address and data captured in either order
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_q         <= 8'h00;
			wd_q         <= 32'h0;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LMD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `LMD_RESP_OKAY : `LMD_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes; status is read-only, low byte needed for control
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q    <= lmd_pkg::lmd_mode_t'(`LMD_RST_MODE);
			half_q    <= `LMD_RST_HALF;
			en_q      <= `LMD_RST_EN;
			ram_acc_q <= 12'h000;
		end else if (do_wr && aw_q == `LMD_OFF_CTRL && ws_q[0]) begin
			en_q   <= wd_q[`LMD_CTRL_EN];
			mode_q <= lmd_pkg::lmd_mode_t'(wd_q[`LMD_CTRL_MODE_HI:`LMD_CTRL_MODE_LO]);
			half_q <= wd_q[`LMD_CTRL_HALF];
		end else if (do_wr && aw_q == `LMD_OFF_RAM && ws_q[1:0] == 2'h3)
			ram_acc_q <= wd_q[11:0];
	end

	// RAM store; columns past the last are dropped
	always_ff @(posedge ref_clk) begin
		if (do_wr && aw_q == `LMD_OFF_RAM && ws_q[1:0] == 2'h3 && wcol < 7'(NSEG))
			ram_q[wcol] <= wd_q[`LMD_RAM_DAT_HI:`LMD_RAM_DAT_LO];
	end

	// Read answer one cycle after address
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `LMD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `LMD_RESP_OKAY;
			case (s_axi_araddr)
				`LMD_OFF_CTRL:   s_axi_rdata <= {28'h0, half_q, mode_q, en_q};
				`LMD_OFF_RAM:    s_axi_rdata <= {20'h0, rram, 1'b0, rcol};
				`LMD_OFF_STATUS: s_axi_rdata <= {20'h0, osc_select_pin,
					frame_rate_select_pin, pol_q, row_q, 2'h0, frame_q};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `LMD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [2:0] past_q;  // Mode and enable one cycle back, behind the pin levels
	always_ff @(posedge ref_clk) past_q <= {mode_q, en_q};
	clk_div_a: assert property (int_tick |=> presc_q == 6'h00)
		else $error("prescaler does not wrap after 64 oscillator periods");
	clk_dir_a: assert property (##1 clk_pin_oe_n == $past(osc_select_pin))
		else $error("clock pin direction wrong");
	ext_clk_a: assert property (osc_select_pin && $rose(clk_pin_i) |-> fclk_tick)
		else $error("external edge not used");
	frame_wrap_a: assert property (fclk_tick && frame_q == FRAME_LAST |=> frame_q == 5'h00)
		else $error("frame not 24 clocks");
	row_range_a: assert property (fclk_tick && phase_st |=> row_q <= 2'($past(mode_q)))
		else $error("row beyond mode");
	off_level_a: assert property (!en_q |=> backplane_outputs == 8'hff
		&& segment_outputs[0] == 2'h3)
		else $error("disabled outputs not at supply");
	mux3_pair_a: assert property (past_q == {2'h2, 1'b1} |-> backplane_outputs[3]
		== backplane_outputs[1])
		else $error("backplane three differs from one");
	mux2_pair_a: assert property (past_q == {2'h1, 1'b1} |-> backplane_outputs[0]
		== backplane_outputs[2] && backplane_outputs[1] == backplane_outputs[3])
		else $error("1:2 backplane pairs differ");
	static_bp_a: assert property (past_q == {2'h0, 1'b1} |-> backplane_outputs
		== {4{backplane_outputs[0]}})
		else $error("static backplanes differ");
	frame_c:  cover property (fclk_tick && frame_q == FRAME_LAST);
	ext_c:    cover property (ext_tick);
	resync_c: cover property (fclk_tick && resync);
	ramwr_c:  cover property (do_wr && aw_q == `LMD_OFF_RAM);
endmodule

/* tb/lmd_glass_model.sv */
// Glass panel and cascade partner: free clock source, pulled-up sync wire, DC monitor
module lmd_glass_model (
	input  wire logic                ref_clk,
	input  wire logic                sync_o,
	input  wire logic                sync_oe_n,
	input  wire lmd_pkg::lmd_level_t bp_pin,
	input  wire lmd_pkg::lmd_level_t seg_pin,
	output logic                     clk_pin_i,
	output logic                     sync_i,
	output logic [31:0]              frame_dc
);
	timeunit 1ns;
	timeprecision 1ps;
	int         acc    = 0;    // Running bp minus seg sum
	logic [2:0] div_q  = 3'h0; // Clock source divider
	logic       sync_q = 1'b1; // Last sync level, for fall detect
	// Shared sync wire has a pull-up; any device may pull it low
	assign sync_i = sync_oe_n ? 1'b1 : sync_o;
	// Never stopped: a halted clock would leave DC across the glass
	assign clk_pin_i = div_q[2];
	////////////////////////////////////////////////////////////////
	// Per-element DC sum, latched once a frame at the sync fall
	always @(posedge ref_clk) begin
		div_q <= div_q + 3'h1;
		sync_q <= sync_i;
		acc = acc + int'(bp_pin) - int'(seg_pin);
		if (sync_q && !sync_i) begin
			frame_dc <= 32'(acc);
			acc = 0;
		end
	end
endmodule

/* tb/lcd_multiplex_drive_timing_bench.sv */
// Self-checking bench for the LCD multiplex drive timing block
`include "lmd_defines.svh"
module lcd_multiplex_drive_timing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] RAM5 = 4'h5; // Column 5 pattern: rows 0 and 2 on
	logic ref_clk, rst_n, osc_sel, ff_sel, clk_in, clk_out, clk_oe_n;
	logic sync_in, sync_out, sync_oe_n;
	lmd_pkg::lmd_level_t [3:0]  bp;
	lmd_pkg::lmd_level_t [79:0] seg;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, frame_dc;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_total, num_checks, cyc;
	lmd_drive_timing uut (.ref_clk(ref_clk), .rst_n(rst_n), .osc_select_pin(osc_sel),
		.frame_rate_select_pin(ff_sel), .clk_pin_i(clk_in), .clk_pin_o(clk_out),
		.clk_pin_oe_n(clk_oe_n), .sync_i(sync_in), .sync_o(sync_out),
		.sync_oe_n(sync_oe_n), .backplane_outputs(bp), .segment_outputs(seg),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	lmd_glass_model glass (.ref_clk(ref_clk), .sync_o(sync_out), .sync_oe_n(sync_oe_n),
		.bp_pin(bp[0]), .seg_pin(seg[5]), .clk_pin_i(clk_in), .sync_i(sync_in),
		.frame_dc(frame_dc));
	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Single closing point for normal end and timeout
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		// Start right after a rising edge, never on the edge of a prior release
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	// AXI4-Lite read: data and response taken at the edge rvalid is seen
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_p;
		ar_p = 1'b1;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (ar_p && s_axi_arready) begin
				ar_p = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// One mode: rows visited, backplane copies, segment level per row, zero DC
	task automatic scan(input logic [1:0] m, input logic [3:0] want);
		logic [3:0] rows;
		logic [1:0] e;
		int r;
		rows = 4'h0;
		axi_wr(8'h00, {28'h0, 1'b0, m, 1'b1}, 2'h0);
		// Long enough for the change to land and one clean frame to latch
		repeat (600) @(posedge ref_clk);
		repeat (192) begin
			@(negedge ref_clk);
			r = 0;
			while (r < 3 && bp[r] != 2'h3 && bp[r] != 2'h0) r++;
			rows[r] = 1'b1;
			e = RAM5[r] ? 2'h0 : ((m == 2'h0) ? 2'h3 : 2'h2);
			e = (bp[r] == 2'h0) ? 2'h3 - e : e;
			chk(32'(seg[5]), 32'(e));
			if (m == 2'h2) chk(32'(bp[3]), 32'(bp[1]));
			if (m == 2'h1) chk(32'({bp[3], bp[2]}), 32'({bp[1], bp[0]}));
			if (m == 2'h0) chk(32'({bp[3], bp[2], bp[1]}), 32'({3{bp[0]}}));
		end
		chk(32'(rows), 32'(want));
		chk(frame_dc, 32'h0);
	endtask
	// Internal oscillator: working clock period seen on the clock pin
	task automatic osc_period(input logic ff, input int osc_cyc);
		time t;
		ff_sel <= ff;
		@(posedge clk_out);
		@(posedge clk_out);
		t = $time;
		@(posedge clk_out);
		chk(32'(($time - t) / 40), 32'(`LMD_OSC_DIV * osc_cyc));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		time         t;
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		{osc_sel, ff_sel, s_axi_wdata} = 34'h3_0000_0000;
		{err_total, num_checks, cyc} = 0;
		repeat (4) @(posedge ref_clk);
		chk(32'(bp), 32'h0000_00ff);
		chk(32'({seg[79], seg[0]}), 32'hf);
		rst_n <= 1'b1;
		axi_rd(8'h00, d, r);
		chk(d, 32'h6);
		axi_rd(8'h08, d, r);
		chk(32'(d[11:10]), 32'h3);
		axi_rd(8'h0c, d, r);
		chk({d[29:0], r}, 32'h2);
		axi_wr(8'h10, 32'h1, 2'h2);
		axi_wr(8'h04, 32'h0000_0505, 2'h0);
		axi_rd(8'h04, d, r);
		chk(32'(d[11:0]), 32'h505);
		// External clock, undivided: 24 ticks of 8 cycles a frame
		@(negedge sync_oe_n);
		t = $time;
		@(negedge sync_oe_n);
		chk(32'(($time - t) / 40), 32'(`LMD_FRAME_TICKS * 8));
		scan(2'h3, 4'hf);
		scan(2'h2, 4'h7);
		scan(2'h1, 4'h3);
		scan(2'h0, 4'h1);
		// Half bias in 1:4: backplane 1 never reaches the upper third
		axi_wr(8'h00, 32'hf, 2'h0);
		repeat (600) @(posedge ref_clk);
		repeat (192) @(negedge ref_clk) chk(32'(bp[1] == 2'h2), 32'h0);
		@(posedge ref_clk);
		osc_sel <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(32'(clk_oe_n), 32'h0);
		osc_period(1'b0, 147);
		osc_period(1'b1, 198);
		osc_sel <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(32'(clk_oe_n), 32'h1);
		give_verdict();
	end
endmodule
